// File: sdoc_pkg.sv
// Operation
// - forward is ccw at 0, cw at 1
// - force stop when limit switch trips
// - forward limit off blocks forward, flags overtravel
// - reverse limit off blocks reverse, flags overtravel
// - phase select 0 single, 1 three, after restart
// - three-phase ignored for 50W to 400W drives
// - phase mismatch with supply raises wiring alarm
// - forward limit disable ignores input, after restart
// - reverse limit disable ignores input, after restart
package sdoc_pkg;

  // ---------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------
  localparam int AW = 5;
  localparam int DW = 32;
  localparam int BEW = 4;

  localparam logic [AW-1:0] OFS_CONFIG   = 5'h00;
  localparam logic [AW-1:0] OFS_STATUS   = 5'h04;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 5'h0c;
  localparam logic [AW-1:0] OFS_CTRL     = 5'h10;

  // ---------------------------------------------------------------
  // config fields
  // ---------------------------------------------------------------
  localparam int CFG_W     = 4;
  localparam int CFG_DIR   = 0;
  localparam int CFG_PHASE = 1;
  localparam int CFG_FDIS  = 2;
  localparam int CFG_RDIS  = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;

  localparam int CTRL_RESTART = 0;

  // ---------------------------------------------------------------
  // events and status
  // ---------------------------------------------------------------
  localparam int EV_W    = 3;
  localparam int EV_FOT  = 0;
  localparam int EV_ROT  = 1;
  localparam int EV_WIRE = 2;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;

  localparam int ST_FLIM  = 4;
  localparam int ST_RLIM  = 5;
  localparam int ST_SUP   = 6;
  localparam int ST_FOT   = 7;
  localparam int ST_ROT   = 8;
  localparam int ST_WIRE  = 9;
  localparam int ST_MOT   = 10;

  // ---------------------------------------------------------------
  // misc
  // ---------------------------------------------------------------
  localparam int RATING_MIN_W = 50;
  localparam int RATING_MAX_W = 400;
  localparam int SYNC_STAGES  = 2;
  localparam int SYNC_W       = 3;
  localparam int SY_FLIM      = 0;
  localparam int SY_RLIM      = 1;
  localparam int SY_SUP       = 2;

  typedef enum logic [3:0] {
    MOT_IDLE = 4'h1,
    MOT_FWD  = 4'h2,
    MOT_REV  = 4'h4,
    MOT_HALT = 4'h8
  } sdoc_mot_t;

endpackage : sdoc_pkg

// File: sdoc_ctrl.sv
`timescale 1ns/10ps
module sdoc_ctrl
  import sdoc_pkg::*;
#(
  parameter int DRIVE_RATING_W = 750
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [AW-1:0]   avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [DW-1:0]   avs_writedata,
  input  wire logic [BEW-1:0]  avs_byteenable,
  output logic      [DW-1:0]   avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            forward_limit_in,
  input  wire logic            reverse_limit_in,
  input  wire logic            supply_three_phase_in,
  input  wire logic            ref_fwd,
  input  wire logic            ref_rev,
  output logic                 drive_ccw,
  output logic                 drive_cw,
  output logic                 motor_stop,
  output logic                 fwd_overtravel,
  output logic                 rev_overtravel,
  output logic                 wiring_error_alarm,
  output logic                 irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam logic RATING_LOW = (DRIVE_RATING_W >= RATING_MIN_W) &&
                                (DRIVE_RATING_W <= RATING_MAX_W);

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic sdoc_mot_t mot_eval(input logic f,
                                         input logic r,
                                         input logic fot,
                                         input logic rot);
    if (f && !r) begin
      mot_eval = fot ? MOT_HALT : MOT_FWD;
    end else if (r && !f) begin
      mot_eval = rot ? MOT_HALT : MOT_REV;
    end else begin
      mot_eval = MOT_IDLE;
    end
  endfunction : mot_eval

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_s;

  assign sync_in[SY_FLIM] = forward_limit_in;
  assign sync_in[SY_RLIM] = reverse_limit_in;
  assign sync_in[SY_SUP]  = supply_three_phase_in;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] ff_r;
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          ff_r <= '0;
        end else begin
          ff_r <= {ff_r[SYNC_STAGES-2:0], sync_in[gi]};
        end
      end
      assign sync_s[gi] = ff_r[SYNC_STAGES-1];
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r,  cfg_nxt;
  logic [CFG_W-1:0] act_r,  act_nxt;
  logic [EV_W-1:0]  ist_r,  ist_nxt;
  logic [EV_W-1:0]  imsk_r, imsk_nxt;
  logic [EV_W-1:0]  cond_r, cond_nxt;
  sdoc_mot_t        mot_r,  mot_nxt;
  logic             wait_r, wait_nxt;
  logic [DW-1:0]    rd_r,   rd_nxt;
  logic             ccw_r,  ccw_nxt;
  logic             cw_r,   cw_nxt;
  logic             stop_r, stop_nxt;
  logic             irq_r,  irq_nxt;

  logic            req;
  logic            wr_acc;
  logic            wr_lo;
  logic            fot;
  logic            rot;
  logic            three_ph;
  logic            wire_err;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  // ---------------------------------------------------------------
  // gating and alarm
  // ---------------------------------------------------------------
  always_comb begin
    fot      = !act_r[CFG_FDIS] && !sync_s[SY_FLIM];
    rot      = !act_r[CFG_RDIS] && !sync_s[SY_RLIM];
    three_ph = act_r[CFG_PHASE] && !RATING_LOW;
    wire_err = three_ph != sync_s[SY_SUP];
    cond_nxt = '0;
    cond_nxt[EV_FOT]  = fot;
    cond_nxt[EV_ROT]  = rot;
    cond_nxt[EV_WIRE] = wire_err;
    ev = cond_nxt & ~cond_r;
  end

  // ---------------------------------------------------------------
  // motion state machine
  // ---------------------------------------------------------------
  always_comb begin
    case (mot_r)
      MOT_HALT: begin
        if (!ref_fwd && !ref_rev) begin
          mot_nxt = MOT_IDLE;
        end else begin
          mot_nxt = mot_eval(ref_fwd, ref_rev, fot, rot);
        end
      end
      default: begin
        mot_nxt = mot_eval(ref_fwd, ref_rev, fot, rot);
      end
    endcase
    ccw_nxt  = ((mot_nxt == MOT_FWD) && !act_r[CFG_DIR]) ||
               ((mot_nxt == MOT_REV) &&  act_r[CFG_DIR]);
    cw_nxt   = ((mot_nxt == MOT_FWD) &&  act_r[CFG_DIR]) ||
               ((mot_nxt == MOT_REV) && !act_r[CFG_DIR]);
    stop_nxt = (mot_nxt == MOT_HALT);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mot_r  <= MOT_IDLE;
      ccw_r  <= 1'b0;
      cw_r   <= 1'b0;
      stop_r <= 1'b0;
      cond_r <= EV_RST;
    end else begin
      mot_r  <= mot_nxt;
      ccw_r  <= ccw_nxt;
      cw_r   <= cw_nxt;
      stop_r <= stop_nxt;
      cond_r <= cond_nxt;
    end
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  always_comb begin
    req      = avs_read || avs_write;
    wr_acc   = avs_write && !wait_r;
    wr_lo    = wr_acc && avs_byteenable[0];
    wait_nxt = !(req && wait_r);
    cfg_nxt  = cfg_r;
    act_nxt  = act_r;
    imsk_nxt = imsk_r;
    clr      = '0;
    rd_nxt   = rd_r;
    if (wr_lo && hit(avs_address, OFS_CONFIG)) begin
      cfg_nxt = avs_writedata[CFG_W-1:0];
    end else if (wr_lo && hit(avs_address, OFS_IRQ_STAT)) begin
      clr = avs_writedata[EV_W-1:0];
    end else if (wr_lo && hit(avs_address, OFS_IRQ_MASK)) begin
      imsk_nxt = avs_writedata[EV_W-1:0];
    end else if (wr_lo && hit(avs_address, OFS_CTRL)) begin
      if (avs_writedata[CTRL_RESTART]) begin
        act_nxt = cfg_r;
      end
    end
    if (avs_read && wait_r) begin
      rd_nxt = '0;
      if (hit(avs_address, OFS_CONFIG)) begin
        rd_nxt[CFG_W-1:0] = cfg_r;
      end else if (hit(avs_address, OFS_STATUS)) begin
        rd_nxt[CFG_W-1:0]        = act_r;
        rd_nxt[ST_FLIM]          = sync_s[SY_FLIM];
        rd_nxt[ST_RLIM]          = sync_s[SY_RLIM];
        rd_nxt[ST_SUP]           = sync_s[SY_SUP];
        rd_nxt[ST_FOT]           = cond_r[EV_FOT];
        rd_nxt[ST_ROT]           = cond_r[EV_ROT];
        rd_nxt[ST_WIRE]          = cond_r[EV_WIRE];
        rd_nxt[ST_MOT+3:ST_MOT]  = mot_r;
      end else if (hit(avs_address, OFS_IRQ_STAT)) begin
        rd_nxt[EV_W-1:0] = ist_r;
      end else if (hit(avs_address, OFS_IRQ_MASK)) begin
        rd_nxt[EV_W-1:0] = imsk_r;
      end
    end
    // set wins over a clear in the same cycle
    ist_nxt = (ist_r & ~clr) | ev;
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rd_r   <= '0;
      cfg_r  <= CFG_RST;
      act_r  <= CFG_RST;
      ist_r  <= EV_RST;
      imsk_r <= EV_RST;
      irq_r  <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rd_r   <= rd_nxt;
      cfg_r  <= cfg_nxt;
      act_r  <= act_nxt;
      ist_r  <= ist_nxt;
      imsk_r <= imsk_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata       = rd_r;
  assign avs_waitrequest    = wait_r;
  assign drive_ccw          = ccw_r;
  assign drive_cw           = cw_r;
  assign motor_stop         = stop_r;
  assign fwd_overtravel     = cond_r[EV_FOT];
  assign rev_overtravel     = cond_r[EV_ROT];
  assign wiring_error_alarm = cond_r[EV_WIRE];
  assign irq                = irq_r;

endmodule : sdoc_ctrl

// File: sdoc_switch_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// travel-end switches: contact on until the end is hit
// ---------------------------------------------------------------
module sdoc_switch_model (
  input  wire logic fwd_hit,
  input  wire logic rev_hit,
  output logic      forward_limit_in,
  output logic      reverse_limit_in
);
  assign forward_limit_in = !fwd_hit;
  assign reverse_limit_in = !rev_hit;
endmodule : sdoc_switch_model

// File: sdoc_ctrl_monitor.sv
`timescale 1ns/10ps
module sdoc_ctrl_monitor #(
  parameter int DRIVE_RATING_W = 750
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ref_fwd,
  input wire logic ref_rev,
  input wire logic forward_limit_in,
  input wire logic reverse_limit_in,
  input wire logic drive_ccw,
  input wire logic drive_cw,
  input wire logic motor_stop,
  input wire logic fwd_overtravel,
  input wire logic rev_overtravel,
  input wire logic wiring_error_alarm,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // motion gating
  // ---------------------------------------------------------------
  dual_drive_a: assert property (!(drive_ccw && drive_cw))
    else $error("both drive outputs high");
  stop_quiet_a: assert property (motor_stop |-> !(drive_ccw || drive_cw))
    else $error("drive active during stop");
  idle_refs_a: assert property ((ref_fwd == ref_rev)
    |=> !(drive_ccw || drive_cw || motor_stop))
    else $error("no single reference but not idle");
  fwd_clear_a: assert property (forward_limit_in [*3] |=> !fwd_overtravel)
    else $error("forward overtravel with switch on");
  rev_clear_a: assert property (reverse_limit_in [*3] |=> !rev_overtravel)
    else $error("reverse overtravel with switch on");
  both_block_a: assert property ($past(ref_fwd ^ ref_rev) &&
    fwd_overtravel && rev_overtravel |-> motor_stop)
    else $error("no stop with both ends blocked");
  free_run_a: assert property ($past(ref_fwd ^ ref_rev) &&
    !fwd_overtravel && !rev_overtravel |-> (drive_ccw ^ drive_cw))
    else $error("no drive while travel allowed");
  stop_cause_a: assert property (motor_stop |-> $past(ref_fwd ^ ref_rev))
    else $error("stop without reference");
  stop_seen_c: cover property (motor_stop);
  irq_seen_c: cover property (irq);
  wire_seen_c: cover property (wiring_error_alarm);
endmodule : sdoc_ctrl_monitor

bind sdoc_ctrl sdoc_ctrl_monitor #(.DRIVE_RATING_W(DRIVE_RATING_W)) mon (.*);

// File: tb_sdoc_ctrl.sv
`timescale 1ns/10ps
module tb_sdoc_ctrl;
  import sdoc_pkg::*;
  logic          sys_clk = 1'h0, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [AW-1:0] avs_address = '0;
  logic [DW-1:0] avs_writedata = '0, avs_readdata, q;
  logic          avs_waitrequest, forward_limit_in, reverse_limit_in, supply_three_phase_in = 1'h0;
  logic          fwd_hit = 1'h0, rev_hit = 1'h0, ref_fwd = 1'h0, ref_rev = 1'h0;
  logic          drive_ccw, drive_cw, motor_stop, fwd_overtravel, rev_overtravel;
  logic          wiring_error_alarm, irq, low_alarm;
  int            errors = 0, n_tests = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  sdoc_switch_model sw (.*);
  sdoc_ctrl dut (.*, .avs_byteenable(4'hf));
  // low-rating drive: three-phase selection has no effect
  sdoc_ctrl #(.DRIVE_RATING_W(400)) dut_low (
    .sys_clk               (sys_clk),
    .rst_b                 (rst_b),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (4'hf),
    .avs_readdata          (),
    .avs_waitrequest       (),
    .forward_limit_in      (forward_limit_in),
    .reverse_limit_in      (reverse_limit_in),
    .supply_three_phase_in (supply_three_phase_in),
    .ref_fwd               (ref_fwd),
    .ref_rev               (ref_rev),
    .drive_ccw             (),
    .drive_cw              (),
    .motor_stop            (),
    .fwd_overtravel        (),
    .rev_overtravel        (),
    .wiring_error_alarm    (low_alarm),
    .irq                   ()
  );
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic cfg(input logic [DW-1:0] v);
    bus(1'h1, OFS_CONFIG, v);
    bus(1'h1, OFS_CTRL, 32'h1);
  endtask : cfg
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_dir;
    for (int d = 0; d < 2; d++) begin
      bus(1'h1, OFS_CONFIG, DW'(d));
      bus(1'h0, OFS_STATUS, '0);
      chk("cfg before restart", '0, DW'(q[3:0]));
      bus(1'h1, OFS_CTRL, 32'h1);
      ref_fwd <= 1'h1;
      wt(3);
      chk("fwd map", d ? 32'h1 : 32'h2, DW'({drive_ccw, drive_cw}));
      ref_fwd <= 1'h0;
      ref_rev <= 1'h1;
      wt(3);
      chk("rev map", d ? 32'h2 : 32'h1, DW'({drive_ccw, drive_cw}));
      ref_rev <= 1'h0;
    end
    cfg('0);
    $display("direction done");
  endtask : t_dir
  task automatic t_lim;
    bus(1'h1, OFS_IRQ_MASK, 32'h3);
    for (int d = 0; d < 2; d++) begin
      bus(1'h1, OFS_IRQ_STAT, 32'h7);
      {rev_hit, fwd_hit} <= d ? 2'h2 : 2'h1;
      {ref_rev, ref_fwd} <= d ? 2'h2 : 2'h1;
      wt(6);
      chk("overtravel", d ? 32'h2 : 32'h1, DW'({rev_overtravel, fwd_overtravel}));
      chk("stop", 32'h4, DW'({motor_stop, drive_ccw, drive_cw}));
      chk("irq set", 32'h1, DW'(irq));
      bus(1'h0, OFS_IRQ_STAT, '0);
      chk("event", d ? 32'h2 : 32'h1, DW'(q[2:0]));
      bus(1'h1, OFS_IRQ_STAT, 32'h3);
      wt(1);
      chk("irq clear", '0, DW'(irq));
      {rev_hit, fwd_hit} <= 2'h0;
      wt(6);
      chk("resume", d ? 32'h1 : 32'h2, DW'({motor_stop, drive_ccw, drive_cw}));
      {ref_rev, ref_fwd} <= 2'h0;
    end
    wt(1);
    {rev_hit, fwd_hit} <= 2'h3;
    ref_fwd <= 1'h1;
    wt(6);
    chk("both blocked", 32'h4, DW'({motor_stop, drive_ccw, drive_cw}));
    ref_fwd <= 1'h0;
    {rev_hit, fwd_hit} <= 2'h0;
    wt(4);
    bus(1'h1, OFS_IRQ_STAT, 32'h7);
    $display("limits done");
  endtask : t_lim
  task automatic t_dis;
    cfg(32'hc);
    {rev_hit, fwd_hit} <= 2'h3;
    ref_fwd <= 1'h1;
    wt(6);
    chk("fwd ignored", 32'h2, DW'({motor_stop, drive_ccw, drive_cw}));
    chk("no overtravel", '0, DW'({fwd_overtravel, rev_overtravel}));
    ref_fwd <= 1'h0;
    ref_rev <= 1'h1;
    wt(3);
    chk("rev ignored", 32'h1, DW'({motor_stop, drive_ccw, drive_cw}));
    ref_rev <= 1'h0;
    {rev_hit, fwd_hit} <= 2'h0;
    wt(4);
    cfg('0);
    $display("disable done");
  endtask : t_dis
  task automatic t_phase;
    cfg(32'h2);
    wt(4);
    chk("alarm", 32'h1, DW'(wiring_error_alarm));
    chk("masked irq", '0, DW'(irq));
    chk("low rating single", '0, DW'(low_alarm));
    supply_three_phase_in <= 1'h1;
    wt(4);
    chk("alarm match", '0, DW'(wiring_error_alarm));
    chk("low rating three", 32'h1, DW'(low_alarm));
    cfg('0);
    wt(4);
    chk("alarm single", 32'h1, DW'(wiring_error_alarm));
    supply_three_phase_in <= 1'h0;
    bus(1'h0, 5'h14, '0);
    chk("unmapped", '0, q);
    $display("phase done");
  endtask : t_phase
  task automatic t_rst;
    bus(1'h1, OFS_CONFIG, 32'hf);
    rst_b <= 1'h0;
    wt(2);
    chk("reset wait", 32'h1, DW'(avs_waitrequest));
    chk("reset outputs", '0, DW'({drive_ccw, drive_cw, motor_stop, fwd_overtravel,
                                  rev_overtravel, wiring_error_alarm, irq}));
    rst_b <= 1'h1;
    wt(3);
    bus(1'h0, OFS_CONFIG, '0);
    chk("config reset", '0, q);
    $display("reset done");
  endtask : t_rst
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    wt(5);
    rst_b <= 1'h1;
    t_dir();
    t_lim();
    t_dis();
    t_phase();
    t_rst();
    print_verdict();
  end
endmodule : tb_sdoc_ctrl
